// >>> design/ocss_pkg.sv
// Shared constants and carrier types for the over-air sync scheduler.
// Assumes one 125 MHz clock clk_sys and a synchronous active-high reset.

package ocss_pkg;

    localparam int          FN_W      = 12;
    localparam logic [11:0] FN_MAX    = 12'hfff;
    localparam logic [11:0] FN_ONE    = 12'h001;
    localparam int          PER_LOG2  = 12;
    localparam logic [25:0] CEIL_BIAS = 26'h0000fff;
    localparam int          TOA_W     = 16;
    localparam int          ACC_W     = 20;

    typedef enum logic [1:0] {
        PH_PRELIM = 2'b00,
        PH_INIT   = 2'b01,
        PH_STEADY = 2'b10
    } ocss_phase_type;

    typedef struct packed {
        logic [12:0] cycles;
        logic [1:0]  sub_log2;
        logic [7:0]  reps;
    } ocss_cfg_type;

    typedef struct packed {
        logic                    fn_update;
        logic [FN_W-1:0]         new_fn;
        logic [FN_W-1:0]         start_fn;
        logic signed [TOA_W-1:0] shift;
    } ocss_adj_type;

    typedef struct packed {
        logic [7:0]              code;
        logic signed [TOA_W-1:0] toa;
        logic [7:0]              sir;
    } ocss_meas_type;

    typedef struct packed {
        ocss_meas_type           meas;
        logic signed [TOA_W-1:0] self_adj;
    } ocss_rpt_type;

endpackage : ocss_pkg

// >>> design/ocss_step.sv
// Gradual timing stepper: spreads a shift over frames.
// Assumes frame_start is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
`default_nettype none

module ocss_step (
    input  wire logic                            clk_sys,
    input  wire logic                            reset,
    input  wire logic                            frame_start,
    input  wire logic                            start,
    input  wire logic                            bulk,
    input  wire logic signed [ocss_pkg::TOA_W-1:0] amount,
    output logic signed [ocss_pkg::TOA_W-1:0]      step,
    output logic                                 busy,
    output logic                                 done
);
    import ocss_pkg::*;

    typedef struct packed {
        logic signed [TOA_W-1:0] rem;
        logic signed [TOA_W-1:0] step;
        logic                    busy;
        logic                    done;
        logic                    bulk;
    } ocss_step_st_type;

    ocss_step_st_type s_reg;
    ocss_step_st_type s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (start) begin
            s_next.rem  = amount;
            s_next.busy = 1'b1;
            s_next.bulk = bulk;
            s_next.step = '0;
        end else if (frame_start && s_reg.busy) begin
            // Last stepped frame is over only at the next boundary
            if (s_reg.rem == '0) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                s_next.step = '0;
            end else if (s_reg.bulk) begin
                s_next.step = s_reg.rem;
                s_next.rem  = '0;
            end else begin
                s_next.step = (s_reg.rem > 0) ? 16'sh0001 : -16'sh0001;
                s_next.rem  = s_reg.rem - s_next.step;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign step = s_reg.step;
    assign busy = s_reg.busy;
    assign done = s_reg.done;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_step_unit: assert property (
        (s_reg.step != '0 && !s_reg.bulk)
        |-> (s_reg.step == 16'sh0001 || s_reg.step == -16'sh0001)
    ) else $error("steady step larger than one sample");

    a_step_frame: assert property (
        ($changed(s_reg.rem) && !$past(start)) |-> $past(frame_start)
    ) else $error("step taken away from a frame start");

endmodule : ocss_step

`default_nettype wire

// >>> design/ocss_sched.sv
// Sync frame schedule: flags frames that carry a sync slot.
// Assumes cycles*subcycles*reps never exceeds the 4096-frame period.
`timescale 1ns/1ps
`default_nettype none

module ocss_sched (
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    input  wire logic                       frame_start,
    input  wire logic [ocss_pkg::FN_W-1:0]  frame_number,
    input  wire ocss_pkg::ocss_cfg_type     cfg,
    output logic                            sync,
    output logic [7:0]                      rep,
    output logic [2:0]                      sub
);
    import ocss_pkg::*;

    typedef struct packed {
        logic       sync;
        logic [7:0] rep;
        logic [2:0] sub;
        logic [7:0] rep_c;
        logic [2:0] sub_c;
    } ocss_sched_st_type;

    ocss_sched_st_type s_reg;
    ocss_sched_st_type s_next;
    logic [23:0] tot_w;
    logic [12:0] n_tot;
    logic [25:0] x0;
    logic [25:0] x1;
    logic        hit;
    logic [3:0]  sub_last;
    logic [7:0]  cr;
    logic [2:0]  cs;

    // Slots sit at floor(n*4096/N); frame f holds one when the
    // ceiling of f*N/4096 steps, so fractional periods need no divider
    always_comb begin
        tot_w = 24'(cfg.cycles * cfg.reps) << cfg.sub_log2;
        n_tot = tot_w[12:0];
        x0 = 26'(frame_number * n_tot) + CEIL_BIAS;
        x1 = 26'(({1'b0, frame_number} + 13'h0001) * n_tot) + CEIL_BIAS;
        hit = (x0[25:PER_LOG2] != x1[25:PER_LOG2]);
        sub_last = 4'((4'h1 << cfg.sub_log2) - 4'h1);
        cr = (frame_number == '0) ? 8'h00 : s_reg.rep_c;
        cs = (frame_number == '0) ? 3'h0 : s_reg.sub_c;
        s_next = s_reg;
        s_next.sync = 1'b0;
        if (frame_start && hit) begin
            s_next.sync = 1'b1;
            s_next.rep = cr;
            s_next.sub = cs;
            if (cr == 8'(cfg.reps - 8'h01)) begin
                s_next.rep_c = '0;
                s_next.sub_c = ({1'b0, cs} == sub_last) ? 3'h0 : 3'(cs + 3'h1);
            end else begin
                s_next.rep_c = 8'(cr + 8'h01);
                s_next.sub_c = cs;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync = s_reg.sync;
    assign rep  = s_reg.rep;
    assign sub  = s_reg.sub;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_first_slot: assert property (
        (frame_start && frame_number == '0 && n_tot != '0)
        |=> (sync && rep == '0 && sub == '0)
    ) else $error("frame zero is not the first sync slot");

    a_slot_on_frame: assert property (
        sync |-> $past(frame_start) && $past(hit)
    ) else $error("sync slot outside a frame start");

endmodule : ocss_sched

`default_nettype wire

// >>> design/ocss_top.sv
// Cell side of over-air base station synchronisation: frame
// timing and numbering, sync slot scheduling, measurement
// averaging, gradual and autonomous timing correction.
// Assumes the controller link logic shares clk_sys; the reference
// strobe, its value and the reference-present level come from pins.
`timescale 1ns/1ps
`default_nettype none

module ocss_top #(
    parameter int          MAX_REP     = 8,
    parameter logic [15:0] FRAME_CYCLES = 16'h0280
) (
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    input  wire logic                          ref_clk_present,
    input  wire logic                          ref_fn_strobe,
    input  wire logic [ocss_pkg::FN_W-1:0]     ref_fn_value,
    input  wire logic [ocss_pkg::FN_W-1:0]     ref_fn_offset,
    input  wire logic                          cell_created,
    input  wire ocss_pkg::ocss_phase_type      phase,
    input  wire logic                          init_tx_turn,
    input  wire ocss_pkg::ocss_cfg_type        cfg,
    input  wire logic [MAX_REP-1:0]            tx_slots,
    input  wire logic [MAX_REP-1:0]            rx_slots,
    input  wire logic [MAX_REP-1:0]            pdc_slots,
    input  wire logic signed [ocss_pkg::TOA_W-1:0] pdc_value,
    input  wire logic                          adj_valid,
    input  wire ocss_pkg::ocss_adj_type        adj,
    input  wire logic                          meas_valid,
    input  wire ocss_pkg::ocss_meas_type       meas,
    output logic                               frame_start,
    output logic [ocss_pkg::FN_W-1:0]          frame_number,
    output logic                               refclk_rpt_valid,
    output logic                               refclk_rpt_avail,
    output logic                               traffic_en,
    output logic                               sync_tx_en,
    output logic                               sync_rx_en,
    output logic                               adj_busy,
    output logic                               adj_resp,
    output logic                               rpt_valid,
    output ocss_pkg::ocss_rpt_type             rpt
);
    import ocss_pkg::*;

    localparam int SLOT_W = (MAX_REP > 1) ? $clog2(MAX_REP) : 1;

    // ==============================================================
    // State
    // ==============================================================
    typedef struct packed {
        logic [15:0]                       samp;
        logic [FN_W-1:0]                   fn;
        logic                              fst;
        logic                              rs1;
        logic                              rs2;
        logic                              rs3;
        logic [FN_W-1:0]                   rv1;
        logic [FN_W-1:0]                   rv2;
        logic                              rc1;
        logic                              rc2;
        logic                              ld_pend;
        logic [FN_W-1:0]                   ld_fn;
        logic                              adj_pend;
        ocss_adj_type                      adj;
        logic                              adj_run;
        logic                              adj_resp;
        logic                              rck_v;
        logic                              rck;
        logic                              traffic;
        logic                              tx_en;
        logic                              rx_en;
        logic [SLOT_W-1:0]                 cur;
        logic [2:0]                        cur_sub;
        logic [MAX_REP-1:0][ACC_W-1:0]     acc;
        logic                              hold_v;
        logic signed [TOA_W-1:0]           hold_toa;
        logic signed [TOA_W-1:0]           self_total;
        logic                              go;
        logic signed [TOA_W-1:0]           amt;
        logic                              bulk;
        logic                              rpt_v;
        ocss_rpt_type                      rpt;
    } ocss_top_st_type;

    ocss_top_st_type s_reg;
    ocss_top_st_type s_next;

    logic                    stp_busy;
    logic                    stp_done;
    logic signed [TOA_W-1:0] stp_step;
    logic                    sync_v;
    logic [7:0]              sync_rep;
    logic [2:0]              sync_sub;
    logic                    ref_edge;
    logic [FN_W-1:0]         ref_fn_sum;
    logic [15:0]             frame_last;
    logic                    ctl_take;
    logic                    self_go;
    logic                    rep_now;
    logic signed [ACC_W-1:0] sum;
    logic signed [ACC_W-1:0] avg_w;
    logic [3:0]              sub_last;

    function automatic logic slot_hit(
        input logic [MAX_REP-1:0] mask,
        input logic [7:0]         idx
    );
        slot_hit = (32'(idx) < MAX_REP) && mask[idx[SLOT_W-1:0]];
    endfunction : slot_hit

    // ==============================================================
    // Schedule and stepper
    // ==============================================================
    ocss_sched u_sched (
        .clk_sys      (clk_sys),
        .reset        (reset),
        .frame_start  (s_reg.fst),
        .frame_number (s_reg.fn),
        .cfg          (cfg),
        .sync         (sync_v),
        .rep          (sync_rep),
        .sub          (sync_sub)
    );

    ocss_step u_step (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .frame_start (s_reg.fst),
        .start       (s_reg.go),
        .bulk        (s_reg.bulk),
        .amount      (s_reg.amt),
        .step        (stp_step),
        .busy        (stp_busy),
        .done        (stp_done)
    );

    // ==============================================================
    // Next state
    // ==============================================================
    // A negative bulk shift must leave the frame at least two cycles
    always_comb begin
        ref_edge   = s_reg.rs2 && !s_reg.rs3;
        ref_fn_sum = s_reg.rv2 + ref_fn_offset;
        frame_last = 16'(FRAME_CYCLES - 16'h0001) + 16'(stp_step);
        sub_last   = 4'((4'h1 << cfg.sub_log2) - 4'h1);
        ctl_take   = s_reg.adj_pend && !adj_valid && s_reg.fst
                     && (phase != PH_STEADY
                         || s_reg.fn == s_reg.adj.start_fn);
        self_go    = sync_v && sync_rep == '0 && sync_sub == '0
                     && s_reg.hold_v && !s_reg.adj_run
                     && !s_reg.adj_pend && !ctl_take;
        rep_now    = 1'b0;
        sum        = {{(ACC_W-TOA_W){meas.toa[TOA_W-1]}}, meas.toa}
                     + $signed(s_reg.acc[s_reg.cur]);
        avg_w      = sum >>> cfg.sub_log2;

        s_next = s_reg;
        s_next.fst      = 1'b0;
        s_next.adj_resp = 1'b0;
        s_next.rpt_v    = 1'b0;
        s_next.rck_v    = 1'b0;
        s_next.go       = 1'b0;

        // Pins pass two flops before any logic reads them
        s_next.rs1 = ref_fn_strobe;
        s_next.rs2 = s_reg.rs1;
        s_next.rs3 = s_reg.rs2;
        s_next.rv1 = ref_fn_value;
        s_next.rv2 = s_reg.rv1;
        s_next.rc1 = ref_clk_present;
        s_next.rc2 = s_reg.rc1;

        if (cell_created) begin
            s_next.rck_v = 1'b1;
            s_next.rck   = s_reg.rc2;
        end

        s_next.traffic = (phase == PH_STEADY);

        // Frame timing and numbering
        if (s_reg.samp >= frame_last) begin
            s_next.samp = '0;
            s_next.fst  = 1'b1;
            s_next.fn   = s_reg.ld_pend ? s_reg.ld_fn
                                        : s_reg.fn + FN_ONE;
            s_next.ld_pend = 1'b0;
        end else begin
            s_next.samp = s_reg.samp + 16'h0001;
        end
        if (ref_edge && s_reg.rc2) begin
            // Reference strobe marks the boundary of its frame
            s_next.samp    = '0;
            s_next.fst     = 1'b1;
            s_next.fn      = ref_fn_sum;
            s_next.ld_pend = 1'b0;
        end

        // Sync code transmit and receive windows
        if (phase == PH_INIT) begin
            s_next.tx_en = init_tx_turn;
            s_next.rx_en = !init_tx_turn;
        end else if (phase == PH_STEADY) begin
            if (s_reg.fst) begin
                s_next.tx_en = 1'b0;
                s_next.rx_en = 1'b0;
            end
            if (sync_v) begin
                s_next.tx_en   = slot_hit(tx_slots, sync_rep);
                s_next.rx_en   = slot_hit(rx_slots, sync_rep);
                s_next.cur     = sync_rep[SLOT_W-1:0];
                s_next.cur_sub = sync_sub;
            end
        end else begin
            s_next.tx_en = 1'b0;
            s_next.rx_en = 1'b0;
        end

        // Controller adjustments
        if (adj_valid) begin
            s_next.adj_pend = 1'b1;
            s_next.adj      = adj;
        end else if (ctl_take) begin
            s_next.adj_pend = 1'b0;
            s_next.adj_run  = 1'b1;
            s_next.go       = 1'b1;
            s_next.amt      = s_reg.adj.shift;
            s_next.bulk     = (phase != PH_STEADY);
            if (s_reg.adj.fn_update && !s_reg.rc2) begin
                s_next.ld_pend = 1'b1;
                s_next.ld_fn   = s_reg.adj.new_fn;
            end
        end
        if (s_reg.adj_run && stp_done) begin
            s_next.adj_run  = 1'b0;
            s_next.adj_resp = 1'b1;
        end

        // Measurements and reports
        if (meas_valid && phase == PH_INIT) begin
            rep_now = 1'b1;
            s_next.rpt.meas = meas;
        end else if (meas_valid && phase == PH_STEADY
                     && s_reg.rx_en) begin
            if ({1'b0, s_reg.cur_sub} == sub_last) begin
                // Last subcycle: sum over all subcycles, shifted right by sub_log2
                rep_now = 1'b1;
                s_next.rpt.meas      = meas;
                s_next.rpt.meas.toa  = avg_w[TOA_W-1:0];
                s_next.acc[s_reg.cur] = '0;
                if (slot_hit(pdc_slots, 8'(s_reg.cur))) begin
                    s_next.hold_v   = 1'b1;
                    s_next.hold_toa = avg_w[TOA_W-1:0];
                end
            end else begin
                s_next.acc[s_reg.cur] = sum;
            end
        end
        if (rep_now) begin
            s_next.rpt_v         = 1'b1;
            s_next.rpt.self_adj  = s_reg.self_total;
            s_next.self_total    = '0;
        end

        // Autonomous correction at the first sync slot of a cycle
        if (self_go) begin
            s_next.go         = 1'b1;
            s_next.amt        = s_reg.hold_toa - pdc_value;
            s_next.bulk       = 1'b0;
            s_next.hold_v     = 1'b0;
            s_next.self_total = (rep_now ? 16'sh0000 : s_reg.self_total)
                                + (s_reg.hold_toa - pdc_value);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==============================================================
    // Outputs
    // ==============================================================
    assign frame_start      = s_reg.fst;
    assign frame_number     = s_reg.fn;
    assign refclk_rpt_valid = s_reg.rck_v;
    assign refclk_rpt_avail = s_reg.rck;
    assign traffic_en       = s_reg.traffic;
    assign sync_tx_en       = s_reg.tx_en;
    assign sync_rx_en       = s_reg.rx_en;
    assign adj_busy         = s_reg.adj_run;
    assign adj_resp         = s_reg.adj_resp;
    assign rpt_valid        = s_reg.rpt_v;
    assign rpt              = s_reg.rpt;

    // ==============================================================
    // Checks
    // ==============================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_ref_load: assert property (
        (ref_edge && s_reg.rc2)
        |=> (s_reg.fst && s_reg.fn == $past(ref_fn_sum))
    ) else $error("reference frame number not loaded");

    a_fn_wrap: assert property (
        (s_reg.samp >= frame_last && !s_reg.ld_pend
         && !(ref_edge && s_reg.rc2))
        |=> s_reg.fn == 12'($past(s_reg.fn) + FN_ONE)
    ) else $error("frame counter did not advance");

    a_no_traffic: assert property (
        (phase != PH_STEADY) |=> !traffic_en
    ) else $error("traffic enabled outside steady state");

    a_init_tx: assert property (
        (phase == PH_INIT && init_tx_turn) |=> sync_tx_en
    ) else $error("sync code not sent during own turn");

    a_init_rpt: assert property (
        (phase == PH_INIT && meas_valid)
        |=> (rpt_valid && rpt.meas.toa == $past(meas.toa))
    ) else $error("initial detection not reported");

    a_resp_done: assert property (
        adj_resp |-> ($past(stp_done) && !adj_busy && !stp_busy)
    ) else $error("response before adjustment finished");

    a_adj_start: assert property (
        ctl_take |=> (s_reg.go && s_reg.amt == $past(s_reg.adj.shift))
    ) else $error("adjustment not started at its frame");

    a_self_cause: assert property (
        $rose(s_reg.hold_v) |-> $past(pdc_slots) != '0
    ) else $error("self correction armed without compensation");

    a_self_rpt: assert property (
        rpt_valid |-> rpt.self_adj == $past(s_reg.self_total)
    ) else $error("report lacks accumulated self adjustment");

endmodule : ocss_top

`default_nettype wire

// >>> tb/ocss_ctl_model.sv
// Controller-side model: issues adjustment requests one at a time.
// Assumes the cell answers every request with one adj_resp pulse.
`timescale 1ns/1ps
`default_nettype none

module ocss_ctl_model (
    input  wire logic                   clk_sys,
    input  wire logic                   send,
    input  wire ocss_pkg::ocss_adj_type req,
    input  wire logic                   adj_resp,
    output logic                        adj_valid,
    output ocss_pkg::ocss_adj_type      adj,
    output logic                        pending
);
    import ocss_pkg::*;
    initial begin
        adj_valid = 1'b0;
        adj       = '0;
        pending   = 1'b0;
    end
    // No new request until answered, so timing is not moved mid-step
    always @(posedge clk_sys) begin
        adj_valid <= send && !pending;
        if (send && !pending)
            adj <= req;
        if (send)
            pending <= 1'b1;
        else if (adj_resp)
            pending <= 1'b0;
    end
endmodule : ocss_ctl_model
`default_nettype wire

// >>> tb/ocss_top_tb.sv
// Self-checking bench for the cell sync scheduler top.
// Assumes the controller model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none

module ocss_top_tb;
    import ocss_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, refp = 1'b0, strobe = 1'b0;
    logic [11:0] refv = 12'h000, refo = 12'h000;
    logic created = 1'b0, turn = 1'b0, send = 1'b0, mv = 1'b0;
    ocss_phase_type ph = PH_PRELIM;
    ocss_adj_type req = '0, adj;
    ocss_meas_type m = '0;
    ocss_cfg_type cf = '{cycles: 13'h0001, sub_log2: 2'h0, reps: 8'h04};
    logic [7:0] pdcs = 8'h00;
    logic signed [15:0] pdcv = 16'sh0000;
    ocss_rpt_type rpt;
    logic fs, rv, ra, ten, txe, rxe, ab, ar, pv, av, pend;
    logic [11:0] fn;
    int miscompares = 0, tests_run = 0, n;
    always #4 clk_sys = ~clk_sys;
    ocss_ctl_model i_ctl (.clk_sys(clk_sys), .send(send), .req(req),
        .adj_resp(ar), .adj_valid(av), .adj(adj), .pending(pend));
    ocss_top #(.MAX_REP(8), .FRAME_CYCLES(16'h0010)) i_dut (
        .clk_sys(clk_sys), .reset(reset), .ref_clk_present(refp),
        .ref_fn_strobe(strobe), .ref_fn_value(refv), .ref_fn_offset(refo),
        .cell_created(created), .phase(ph), .init_tx_turn(turn),
        .cfg(cf), .tx_slots(8'h01), .rx_slots(8'h02), .pdc_slots(pdcs),
        .pdc_value(pdcv), .adj_valid(av), .adj(adj),
        .meas_valid(mv), .meas(m), .frame_start(fs), .frame_number(fn),
        .refclk_rpt_valid(rv), .refclk_rpt_avail(ra), .traffic_en(ten),
        .sync_tx_en(txe), .sync_rx_en(rxe), .adj_busy(ab),
        .adj_resp(ar), .rpt_valid(pv), .rpt(rpt));
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_fs;
        n = 0;
        tick(1);
        while (fs !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk(fs, 1'b1);
    endtask : wait_fs
    task automatic rx_meas(input int k, input logic [15:0] toa);
        repeat (k) wait_fs();
        tick(2);
        m.toa = toa;
        mv = 1'b1;
        tick(1);
        mv = 1'b0;
    endtask : rx_meas
    task automatic tally_and_finish;
        $display("counts: %0d compares, %0d mismatches", tests_run,
                 miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        #160000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        tick(3);
        reset = 1'b0;
        chk(fn, 12'h000);
        // Load just after a boundary so no free frame start interferes
        refp = 1'b1; refv = 12'hffe; refo = 12'h001; tick(4);
        wait_fs();
        strobe = 1'b1;
        wait_fs();
        chk(fn, 12'hfff);
        strobe = 1'b0;
        wait_fs();
        chk(fn, 12'h000);
        wait_fs();
        chk(n + 1, 16);
        $display("test frame load done");
        created = 1'b1; tick(1); created = 1'b0;
        chk({rv, ra}, 2'b11);
        ph = PH_INIT; turn = 1'b1; tick(4);
        chk({ten, txe, rxe}, 3'b010);
        m = '{code: 8'h5a, toa: 16'sh0123, sir: 8'h40};
        mv = 1'b1; tick(1); mv = 1'b0;
        chk({pv, rpt.meas}, {1'b1, m});
        $display("test initial phase done");
        refp = 1'b0; tick(4);
        req = '{fn_update: 1'b1, new_fn: 12'h123, start_fn: 12'h000,
                shift: 16'sh0002};
        send = 1'b1; tick(1); send = 1'b0;
        wait_fs();
        wait_fs();
        chk(fn, 12'h123);
        n = 0;
        while (ar !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        chk({ar, ab}, 2'b10);
        ph = PH_STEADY; tick(3);
        chk({ten, pend}, 2'b10);
        $display("test adjustment done");
        // Every frame a slot: four repetitions, two subcycles a cycle
        cf = '{cycles: 13'h0200, sub_log2: 2'h1, reps: 8'h04};
        pdcs = 8'h02; pdcv = 16'sh0026; refp = 1'b1; refv = 12'hfff;
        tick(4);
        wait_fs();
        strobe = 1'b1;
        wait_fs();
        strobe = 1'b0;
        chk(fn, 12'h000);
        tick(2);
        chk({txe, rxe}, 2'b10);
        rx_meas(1, 16'h0020);
        chk({txe, rxe, pv}, 3'b010);
        rx_meas(4, 16'h0030);
        chk({pv, rpt.meas.toa, rpt.self_adj},
            {1'b1, 16'h0028, 16'h0000});
        // Held 0x28 against 0x26 gives a two-sample self step
        rx_meas(4, 16'h0028);
        rx_meas(4, 16'h0028);
        chk({pv, rpt.meas.toa, rpt.self_adj},
            {1'b1, 16'h0028, 16'h0002});
        $display("test steady schedule done");
        tally_and_finish();
    end
endmodule : ocss_top_tb
`default_nettype wire
